// ### rtl/caio_top.v
// Purpose: alu datapath and i/o space access engine behind a wishbone slave
// Assumes: classic wishbone, 8-bit data in lane 0, one cycle to ack
// Notes:   commands run from the command register; bus writes are acked but dropped while busy
// What this block does
// - add and add-with-carry, flags, one cycle
// - add immediate to pair, two cycles
// - subtract and subtract-with-borrow, one cycle
// - subtract immediate forms, one cycle
// - subtract immediate from pair, two cycles
// - and forms keep carry and half-carry
// - or forms update zero, negative, overflow
// - exclusive or updates zero, negative, overflow
// - invert and negate with their flags
// - bit set, clear, tests only below 0x20
// - bit writes touch only the addressed bit
// - in/out reach i/o addresses 0x00-0x3f
// - data-space address is i/o address plus 0x20
// - extended area only through data-space access
//
// The address map and register access over Wishbone were decided locally.
`timescale 1ns/100ps
`include "caio_map.vh"
module caio_top (
    input  wire        sys_clk,
    input  wire        reset_n,
    input  wire        wb_cyc,
    input  wire        wb_stb,
    input  wire        wb_we,
    input  wire [11:0] wb_adr,
    input  wire [3:0]  wb_sel,
    input  wire [31:0] wb_dat_w,
    output reg  [31:0] wb_dat_r,
    output reg         wb_ack
);
    localparam S_IDLE  = 2'd0;
    localparam S_EXEC  = 2'd1;
    localparam S_WORD2 = 2'd2;
    localparam W_CTRL  = 2'd0;
    localparam W_RF    = 2'd1;
    localparam W_DS    = 2'd2;
    localparam W_NONE  = 2'd3;

    reg        rst_q1;
    reg        rst_n_s;
    reg [1:0]  state;
    reg [4:0]  op_reg;
    reg [4:0]  rd_sel;
    reg [4:0]  rr_sel;
    reg [7:0]  imm;
    reg [2:0]  bit_sel;
    reg [7:0]  sreg;
    reg        skip;
    reg        fault;
    reg [7:0]  word_hi;
    reg [7:0]  word_flags;
    reg [7:0]  rf [0:31];

    reg        rf_we;
    reg [4:0]  rf_wi;
    reg [7:0]  rf_wd;
    reg        io_we;
    reg [7:0]  io_wa;
    reg [7:0]  io_wd;
    reg [7:0]  io_wm;
    reg [7:0]  io_ra;
    reg        ex_skip;
    reg        ex_fault;
    reg [7:0]  rd_mux;

    wire       bus_req = wb_cyc & wb_stb;
    wire       wr_fire = bus_req & wb_we & wb_ack & wb_sel[0];
    wire [1:0] bus_win = win_of(wb_adr);
    wire [7:0] ds_bus  = wb_adr[9:2];
    wire [7:0] ds_io   = imm + `CAIO_IO_OFS;
    wire       word_op = (op_reg == `CAIO_OP_ADDW) || (op_reg == `CAIO_OP_SUBW);
    wire       imm_op  = (op_reg == `CAIO_OP_SUBK) || (op_reg == `CAIO_OP_SUBCK) ||
                         (op_reg == `CAIO_OP_ANDK) || (op_reg == `CAIO_OP_ORK) || word_op;
    wire [4:0] rd_hi   = rd_sel + 5'd1;
    wire [7:0] io_rda;
    wire [7:0] io_rdb;
    wire [7:0] alu_res;
    wire [15:0] alu_wres;
    wire [7:0] alu_flags;
    wire [7:0] alu_upd;

    // which bus window an address falls in
    function [1:0] win_of;
        input [11:0] adr;
        begin
            if (adr < `CAIO_CTRL_TOP)
                win_of = W_CTRL;
            else if (adr >= `CAIO_A_RF_LO && adr <= `CAIO_A_RF_HI)
                win_of = W_RF;
            else if (adr >= `CAIO_A_DS_LO && adr <= `CAIO_A_DS_HI)
                win_of = W_DS;
            else
                win_of = W_NONE;
        end
    endfunction

    caio_alu u_alu (
        .op    (op_reg),
        .a     (rf[rd_sel]),
        .b     (imm_op ? imm : rf[rr_sel]),
        .cflag (sreg[`CAIO_F_C]),
        .pair  ({rf[rd_hi], rf[rd_sel]}),
        .res   (alu_res),
        .wres  (alu_wres),
        .flags (alu_flags),
        .upd   (alu_upd)
    );

    caio_iospace u_io (
        .sys_clk   (sys_clk),
        .wr_en     (io_we),
        .wr_addr   (io_wa),
        .wr_data   (io_wd),
        .wr_mask   (io_wm),
        .rd_addr_a (io_ra),
        .rd_data_a (io_rda),
        .rd_addr_b (ds_bus),
        .rd_data_b (io_rdb)
    );

    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_q1  <= 1'b0;
            rst_n_s <= 1'b0;
        end else begin
            rst_q1  <= 1'b1;
            rst_n_s <= rst_q1;
        end
    end

    // write side of the register file, the i/o space and the execute results
    always @* begin
        rf_we    = 1'b0;
        rf_wi    = rd_sel;
        rf_wd    = alu_res;
        io_we    = 1'b0;
        io_wa    = ds_io;
        io_wd    = `CAIO_ZERO;
        io_wm    = `CAIO_ONES;
        io_ra    = ds_io;
        ex_skip  = 1'b0;
        ex_fault = 1'b0;
        if (state == S_EXEC) begin
            case (op_reg)
                `CAIO_OP_ADDW, `CAIO_OP_SUBW: begin
                    rf_we = 1'b1;
                    rf_wd = alu_wres[7:0];
                end
                `CAIO_OP_BSET, `CAIO_OP_BCLR: begin
                    if (imm <= `CAIO_IO_BIT_MAX) begin
                        io_we = 1'b1;
                        io_wm = 8'h01 << bit_sel;
                        io_wd = (op_reg == `CAIO_OP_BSET) ? `CAIO_ONES : `CAIO_ZERO;
                    end else begin
                        ex_fault = 1'b1;
                    end
                end
                `CAIO_OP_SKBS, `CAIO_OP_SKBC: begin
                    if (imm <= `CAIO_IO_BIT_MAX)
                        ex_skip = (io_rda[bit_sel] == (op_reg == `CAIO_OP_SKBS));
                    else
                        ex_fault = 1'b1;
                end
                `CAIO_OP_IN: begin
                    if (imm <= `CAIO_IO_MAX) begin
                        rf_we = 1'b1;
                        rf_wd = io_rda;
                    end else begin
                        ex_fault = 1'b1;
                    end
                end
                `CAIO_OP_OUT: begin
                    if (imm <= `CAIO_IO_MAX) begin
                        io_we = 1'b1;
                        io_wd = rf[rd_sel];
                    end else begin
                        ex_fault = 1'b1;
                    end
                end
                `CAIO_OP_MRD: begin
                    io_ra = imm;
                    rf_we = 1'b1;
                    rf_wd = (imm < `CAIO_IO_OFS) ? rf[imm[4:0]] : io_rda;
                end
                `CAIO_OP_MWR: begin
                    io_wa = imm;
                    io_wd = rf[rd_sel];
                    if (imm < `CAIO_IO_OFS) begin
                        rf_we = 1'b1;
                        rf_wi = imm[4:0];
                        rf_wd = rf[rd_sel];
                    end else begin
                        io_we = 1'b1;
                    end
                end
                default: begin
                    if (op_reg <= `CAIO_OP_TWOS)
                        rf_we = 1'b1;
                    else
                        ex_fault = 1'b1;
                end
            endcase
        end else if (state == S_WORD2) begin
            rf_we = 1'b1;
            rf_wi = rd_hi;
            rf_wd = word_hi;
        end else if (wr_fire && bus_win == W_RF) begin
            rf_we = 1'b1;
            rf_wi = wb_adr[6:2];
            rf_wd = wb_dat_w[7:0];
        end else if (wr_fire && bus_win == W_DS) begin
            io_wa = ds_bus;
            io_wd = wb_dat_w[7:0];
            rf_wi = ds_bus[4:0];
            rf_wd = wb_dat_w[7:0];
            if (ds_bus < `CAIO_IO_OFS)
                rf_we = 1'b1;
            else
                io_we = 1'b1;
        end
    end

    always @(posedge sys_clk) begin
        if (rf_we) begin
            rf[rf_wi] <= rf_wd;
        end
    end

    // bus read data
    always @* begin
        rd_mux = `CAIO_ZERO;
        case (bus_win)
            W_CTRL: begin
                case (wb_adr)
                    `CAIO_A_CMD:  rd_mux = {3'b000, op_reg};
                    `CAIO_A_RD:   rd_mux = {3'b000, rd_sel};
                    `CAIO_A_RR:   rd_mux = {3'b000, rr_sel};
                    `CAIO_A_IMM:  rd_mux = imm;
                    `CAIO_A_BIT:  rd_mux = {5'b00000, bit_sel};
                    `CAIO_A_SREG: rd_mux = sreg;
                    `CAIO_A_STAT: rd_mux = {5'b00000, fault, skip, state != S_IDLE};
                    default:      rd_mux = `CAIO_ZERO;
                endcase
            end
            W_RF:    rd_mux = rf[wb_adr[6:2]];
            W_DS:    rd_mux = (ds_bus < `CAIO_IO_OFS) ? rf[ds_bus[4:0]] : io_rdb;
            default: rd_mux = `CAIO_ZERO;
        endcase
    end

    always @(posedge sys_clk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            wb_ack     <= 1'b0;
            wb_dat_r   <= 32'h00000000;
            state      <= S_IDLE;
            op_reg     <= 5'h00;
            rd_sel     <= 5'h00;
            rr_sel     <= 5'h00;
            imm        <= 8'h00;
            bit_sel    <= 3'h0;
            sreg       <= 8'h00;
            skip       <= 1'b0;
            fault      <= 1'b0;
            word_hi    <= 8'h00;
            word_flags <= 8'h00;
        end else begin
            wb_ack <= bus_req & ~wb_ack;
            if (bus_req && !wb_ack && !wb_we) begin
                wb_dat_r <= {24'h000000, rd_mux};
            end
            case (state)
                S_IDLE: begin
                    if (wr_fire && bus_win == W_CTRL) begin
                        case (wb_adr)
                            `CAIO_A_CMD: begin
                                op_reg <= wb_dat_w[4:0];
                                state  <= S_EXEC;
                                skip   <= 1'b0;
                                fault  <= 1'b0;
                            end
                            `CAIO_A_RD:   rd_sel  <= wb_dat_w[4:0];
                            `CAIO_A_RR:   rr_sel  <= wb_dat_w[4:0];
                            `CAIO_A_IMM:  imm     <= wb_dat_w[7:0];
                            `CAIO_A_BIT:  bit_sel <= wb_dat_w[2:0];
                            `CAIO_A_SREG: sreg    <= wb_dat_w[7:0];
                            default:      state   <= S_IDLE;
                        endcase
                    end
                end
                S_EXEC: begin
                    skip  <= ex_skip;
                    fault <= ex_fault;
                    if (word_op) begin
                        word_hi    <= alu_wres[15:8];
                        word_flags <= alu_flags;
                        state      <= S_WORD2;
                    end else begin
                        sreg  <= (sreg & ~alu_upd) | (alu_flags & alu_upd);
                        state <= S_IDLE;
                    end
                end
                S_WORD2: begin
                    sreg  <= (sreg & ~alu_upd) | (word_flags & alu_upd);
                    state <= S_IDLE;
                end
                default: state <= S_IDLE;
            endcase
        end
    end
endmodule

// ### rtl/caio_map.vh
// Purpose: constants shared by the alu and i/o access block
// Assumes: byte addresses on a 12-bit wishbone address, 8-bit data in lane 0
// Notes:   opcodes are the values written to the command register
`ifndef CAIO_MAP_VH
`define CAIO_MAP_VH

// command register opcodes
`define CAIO_OP_ADD   5'h00
`define CAIO_OP_ADC   5'h01
`define CAIO_OP_SUB   5'h02
`define CAIO_OP_SUBC  5'h03
`define CAIO_OP_SUBK  5'h04
`define CAIO_OP_SUBCK 5'h05
`define CAIO_OP_AND   5'h06
`define CAIO_OP_ANDK  5'h07
`define CAIO_OP_OR    5'h08
`define CAIO_OP_ORK   5'h09
`define CAIO_OP_XOR   5'h0a
`define CAIO_OP_INV   5'h0b
`define CAIO_OP_TWOS  5'h0c
`define CAIO_OP_ADDW  5'h0d
`define CAIO_OP_SUBW  5'h0e
`define CAIO_OP_BSET  5'h0f
`define CAIO_OP_BCLR  5'h10
`define CAIO_OP_SKBS  5'h11
`define CAIO_OP_SKBC  5'h12
`define CAIO_OP_IN    5'h13
`define CAIO_OP_OUT   5'h14
`define CAIO_OP_MRD   5'h15
`define CAIO_OP_MWR   5'h16

// status register flag positions
`define CAIO_F_C 0
`define CAIO_F_Z 1
`define CAIO_F_N 2
`define CAIO_F_V 3
`define CAIO_F_S 4
`define CAIO_F_H 5

// control register byte addresses
`define CAIO_A_CMD    12'h000
`define CAIO_A_RD     12'h004
`define CAIO_A_RR     12'h008
`define CAIO_A_IMM    12'h00c
`define CAIO_A_BIT    12'h010
`define CAIO_A_SREG   12'h014
`define CAIO_A_STAT   12'h018
`define CAIO_CTRL_TOP 12'h01c
// windows: general registers and data space, one byte per word
`define CAIO_A_RF_LO  12'h400
`define CAIO_A_RF_HI  12'h47c
`define CAIO_A_DS_LO  12'h800
`define CAIO_A_DS_HI  12'hbfc

// i/o space limits, in i/o addresses except CAIO_EXT_LO, which is a data-space address
`define CAIO_IO_OFS     8'h20
`define CAIO_IO_BIT_MAX 8'h1f
`define CAIO_IO_MAX     8'h3f
`define CAIO_EXT_LO     8'h60
`define CAIO_ONES       8'hff
`define CAIO_ZERO       8'h00

// status register bits
`define CAIO_STAT_BUSY  0
`define CAIO_STAT_SKIP  1
`define CAIO_STAT_FAULT 2

`endif

// ### rtl/caio_alu.v
// Purpose: combinational 8-bit and register-pair arithmetic with flags
// Assumes: cflag is the current carry flag
// Notes:   upd marks which status flags the operation writes
`timescale 1ns/100ps
`include "caio_map.vh"
module caio_alu (
    input  wire [4:0]  op,
    input  wire [7:0]  a,
    input  wire [7:0]  b,
    input  wire        cflag,
    input  wire [15:0] pair,
    output reg  [7:0]  res,
    output reg  [15:0] wres,
    output reg  [7:0]  flags,
    output reg  [7:0]  upd
);
    reg [7:0]  x;
    reg [7:0]  y;
    reg        ci;
    reg [8:0]  sum;
    reg [8:0]  dif;
    reg [15:0] k16;

    always @* begin
        x = a;
        y = b;
        ci = 1'b0;
        if (op == `CAIO_OP_ADC || op == `CAIO_OP_SUBC || op == `CAIO_OP_SUBCK) begin
            ci = cflag;
        end
        if (op == `CAIO_OP_TWOS) begin
            x = `CAIO_ZERO;
            y = a;
        end
        sum = {1'b0, x} + {1'b0, y} + {8'h00, ci};
        dif = {1'b0, x} - {1'b0, y} - {8'h00, ci};
        k16 = {10'h000, b[5:0]};
        res = `CAIO_ZERO;
        wres = 16'h0000;
        flags = 8'h00;
        upd = 8'h00;
        case (op)
            `CAIO_OP_ADD, `CAIO_OP_ADC: begin
                res = sum[7:0];
                flags[`CAIO_F_C] = sum[8];
                flags[`CAIO_F_H] = (x[3] & y[3]) | (y[3] & ~res[3]) | (~res[3] & x[3]);
                flags[`CAIO_F_V] = (x[7] & y[7] & ~res[7]) | (~x[7] & ~y[7] & res[7]);
                upd = 8'h2f;
            end
            `CAIO_OP_SUB, `CAIO_OP_SUBC, `CAIO_OP_SUBK, `CAIO_OP_SUBCK,
            `CAIO_OP_TWOS: begin
                res = dif[7:0];
                flags[`CAIO_F_C] = dif[8];
                flags[`CAIO_F_H] = (~x[3] & y[3]) | (y[3] & res[3]) | (res[3] & ~x[3]);
                flags[`CAIO_F_V] = (x[7] & ~y[7] & ~res[7]) | (~x[7] & y[7] & res[7]);
                upd = 8'h2f;
            end
            `CAIO_OP_AND, `CAIO_OP_ANDK: begin
                res = a & b;
                upd = 8'h0e;
            end
            `CAIO_OP_OR, `CAIO_OP_ORK: begin
                res = a | b;
                upd = 8'h0e;
            end
            `CAIO_OP_XOR: begin
                res = a ^ b;
                upd = 8'h0e;
            end
            `CAIO_OP_INV: begin
                res = `CAIO_ONES - a;
                flags[`CAIO_F_C] = 1'b1;
                upd = 8'h0f;
            end
            `CAIO_OP_ADDW: begin
                wres = pair + k16;
                flags[`CAIO_F_C] = ~wres[15] & pair[15];
                flags[`CAIO_F_V] = ~pair[15] & wres[15];
                upd = 8'h1f;
            end
            `CAIO_OP_SUBW: begin
                wres = pair - k16;
                flags[`CAIO_F_C] = wres[15] & ~pair[15];
                flags[`CAIO_F_V] = pair[15] & ~wres[15];
                upd = 8'h1f;
            end
            default: begin
                upd = 8'h00;
            end
        endcase
        if (op == `CAIO_OP_ADDW || op == `CAIO_OP_SUBW) begin
            flags[`CAIO_F_N] = wres[15];
            flags[`CAIO_F_Z] = (wres == 16'h0000);
        end else begin
            flags[`CAIO_F_N] = res[7];
            flags[`CAIO_F_Z] = (res == `CAIO_ZERO);
        end
        flags[`CAIO_F_S] = flags[`CAIO_F_N] ^ flags[`CAIO_F_V];
    end
endmodule

// ### rtl/caio_iospace.v
// Purpose: i/o and extended i/o storage indexed by data-space address
// Assumes: writes carry a bit mask; unmasked bits keep their value
// Notes:   two read ports, one for the engine and one for the bus
`timescale 1ns/100ps
`include "caio_map.vh"
module caio_iospace (
    input  wire       sys_clk,
    input  wire       wr_en,
    input  wire [7:0] wr_addr,
    input  wire [7:0] wr_data,
    input  wire [7:0] wr_mask,
    input  wire [7:0] rd_addr_a,
    output wire [7:0] rd_data_a,
    input  wire [7:0] rd_addr_b,
    output wire [7:0] rd_data_b
);
    reg [7:0] mem [0:255];

    assign rd_data_a = mem[rd_addr_a];
    assign rd_data_b = mem[rd_addr_b];

    // only masked bits change, so write-one-to-clear neighbours are left alone
    always @(posedge sys_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= (mem[wr_addr] & ~wr_mask) | (wr_data & wr_mask);
        end
    end
endmodule

// ### test/caio_top_assertions.sv
// Purpose: bus timing and read-data checks on the alu and i/o access block
// Assumes: classic wishbone slave answering one cycle after a request
// Notes:   sees only the top module ports
`timescale 1ns/100ps
`include "caio_map.vh"
module caio_top_assertions (
    input wire logic        sys_clk,
    input wire logic        reset_n,
    input wire logic        wb_cyc,
    input wire logic        wb_stb,
    input wire logic        wb_we,
    input wire logic [11:0] wb_adr,
    input wire logic [3:0]  wb_sel,
    input wire logic [31:0] wb_dat_w,
    input wire logic [31:0] wb_dat_r,
    input wire logic        wb_ack
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    wire rd_ack = wb_ack && !wb_we;
    sequence s_req;
        wb_cyc && wb_stb && !wb_ack;
    endsequence
    sequence s_ack;
        wb_ack ##1 !wb_ack;
    endsequence
    chk_reset_quiet: assert property (disable iff (1'b0)
        !reset_n |-> !wb_ack && wb_dat_r == 32'h0)
        else $error("bus outputs active during reset");
    chk_req_acked: assert property (s_req |=> s_ack)
        else $error("request not answered by a single ack pulse");
    chk_ack_has_req: assert property (wb_ack |-> $past(wb_cyc && wb_stb && !wb_ack))
        else $error("ack without a fresh request");
    chk_idle_quiet: assert property (!wb_cyc ##1 !wb_cyc |-> !wb_ack)
        else $error("ack while bus idle");
    chk_upper_zero: assert property (wb_dat_r[31:8] == 24'h0)
        else $error("read data upper lanes not zero");
    chk_rdata_hold: assert property ($changed(wb_dat_r) |-> rd_ack)
        else $error("read data moved outside a read ack");
    chk_unmapped_zero: assert property (rd_ack && wb_adr >= `CAIO_CTRL_TOP
        && wb_adr < `CAIO_A_RF_LO |-> wb_dat_r == 32'h0)
        else $error("unmapped read not zero");
    chk_status_spare: assert property (rd_ack && wb_adr == `CAIO_A_STAT
        |-> wb_dat_r[7:3] == 5'h00)
        else $error("status spare bits set");
endmodule
bind caio_top caio_top_assertions i_chk (.sys_clk(sys_clk), .reset_n(reset_n),
    .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel),
    .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack));

// ### test/caio_tb.sv
// Purpose: self-checking bench for the alu and i/o access block
// Assumes: one cycle ack, commands polled to idle through status
// Notes:   all status flags are compared, carry of the invert included
`timescale 1ns/100ps
`include "caio_map.vh"
module testbench;
    reg         sys_clk = 1'b0, reset_n = 1'b1, wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
    reg  [11:0] wb_adr = 12'h000;
    reg  [3:0]  wb_sel = 4'h0;
    reg  [31:0] wb_dat_w = 32'h0, seed = 32'h550a, q;
    wire [31:0] wb_dat_r;
    wire        wb_ack;
    integer     bad_count = 0, samples_checked = 0, cycles = 0, k;
    reg  [7:0]  a, b, sr, v, p;
    reg  [4:0]  rd, op;
    reg  [2:0]  bt;
    reg  [15:0] ex;
    reg  [23:0] ew;

    caio_top i_dut (.sys_clk(sys_clk), .reset_n(reset_n), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
        .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w),
        .wb_dat_r(wb_dat_r), .wb_ack(wb_ack));

    initial begin
        forever #2.5 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            bad_count = bad_count + 1;
            final_report;
        end
    end

    function [7:0] rnd();
        begin
            repeat (8) seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
            rnd = seed[7:0];
        end
    endfunction

    function [11:0] rfa(input [4:0] n);
        rfa = `CAIO_A_RF_LO + {5'h0, n, 2'b00};
    endfunction

    function [11:0] dsa(input [7:0] d);
        dsa = `CAIO_A_DS_LO + {2'b00, d, 2'b00};
    endfunction

    // {status after, result}; s holds the status before
    function [15:0] alu8(input [4:0] o, input [7:0] x, input [7:0] y, input [7:0] s);
        reg [8:0] r;
        reg       ci;
        begin
            ci = (o == `CAIO_OP_ADC || o == `CAIO_OP_SUBC || o == `CAIO_OP_SUBCK) & s[0];
            alu8 = {s, 8'h00};
            r = 9'h000;
            if (o == `CAIO_OP_TWOS) begin
                y = x;
                x = 8'h00;
            end
            case (o)
                `CAIO_OP_ADD, `CAIO_OP_ADC: begin
                    r = {1'b0, x} + y + ci;
                    alu8[13] = (x[3:0] + y[3:0] + ci) > 5'h0f;
                    alu8[11] = (x[7] == y[7]) && (r[7] != x[7]);
                    alu8[8] = r[8];
                end
                `CAIO_OP_AND, `CAIO_OP_ANDK: r = {1'b0, x & y};
                `CAIO_OP_OR, `CAIO_OP_ORK: r = {1'b0, x | y};
                `CAIO_OP_XOR: r = {1'b0, x ^ y};
                `CAIO_OP_INV: begin
                    r = {1'b0, ~x};
                    alu8[8] = 1'b1;
                end
                default: begin
                    r = {1'b0, x} - y - ci;
                    alu8[13] = {1'b0, x[3:0]} < y[3:0] + ci;
                    alu8[11] = (x[7] != y[7]) && (r[7] != x[7]);
                    alu8[8] = r[8];
                end
            endcase
            if (o >= `CAIO_OP_AND && o <= `CAIO_OP_INV)
                alu8[11] = 1'b0;
            alu8[7:0] = r[7:0];
            alu8[9] = r[7:0] == 8'h00;
            alu8[10] = r[7];
        end
    endfunction

    function [23:0] alu16(input sub, input [15:0] w, input [5:0] n, input [7:0] s);
        reg [16:0] r;
        begin
            r = sub ? {1'b0, w} - n : {1'b0, w} + n;
            alu16 = {s, r[15:0]};
            alu16[16] = r[16];
            alu16[17] = r[15:0] == 16'h0000;
            alu16[18] = r[15];
            alu16[19] = sub ? (w[15] & ~r[15]) : (~w[15] & r[15]);
            alu16[20] = alu16[18] ^ alu16[19];
        end
    endfunction

    task bus(input w, input [11:0] ad, input [7:0] d);
        begin
            @(posedge sys_clk);
            wb_cyc <= 1'b1;
            wb_stb <= 1'b1;
            wb_we <= w;
            wb_adr <= ad;
            wb_sel <= 4'h1;
            wb_dat_w <= {24'h0, d};
            @(posedge sys_clk);
            while (wb_ack !== 1'b1) @(posedge sys_clk);
            q = wb_dat_r;
            wb_cyc <= 1'b0;
            wb_stb <= 1'b0;
        end
    endtask

    // loads the selects, starts the command, leaves status in q
    task cmd(input [4:0] o, input [4:0] d, input [4:0] s, input [7:0] n, input [2:0] t);
        begin
            bus(1'b1, `CAIO_A_RD, {3'b000, d});
            bus(1'b1, `CAIO_A_RR, {3'b000, s});
            bus(1'b1, `CAIO_A_IMM, n);
            bus(1'b1, `CAIO_A_BIT, {5'h00, t});
            bus(1'b1, `CAIO_A_CMD, {3'b000, o});
            q = 32'h1;
            while (q[0] !== 1'b0) bus(1'b0, `CAIO_A_STAT, 8'h00);
        end
    endtask

    task check(input [31:0] seen, input [31:0] want);
        begin
            samples_checked = samples_checked + 1;
            if (seen !== want) begin
                bad_count = bad_count + 1;
                $display("wrong value at %0t: saw %h expected %h", $time, seen, want);
            end
        end
    endtask

    task final_report;
        begin
            $display("checks %0d mismatches %0d", samples_checked, bad_count);
            if (bad_count == 0 && samples_checked > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask

    initial begin
        reset_n <= 1'b0;
        repeat (10) @(posedge sys_clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        for (k = 0; k < 120; k = k + 1) begin
            op = k / 8;
            a = rnd();
            b = rnd();
            sr = rnd();
            v = rnd();
            rd = v[4:0];
            v = rnd();
            // signed overflow and register wrap corners
            if (k % 8 == 0) begin
                a = 8'h7f;
                b = 8'h01;
            end
            if (k % 8 == 1) begin
                a = 8'h80;
                b = 8'h80;
                rd = 5'h1f;
            end
            bus(1'b1, `CAIO_A_SREG, sr);
            bus(1'b1, rfa(rd), a);
            bus(1'b1, rfa(rd + 5'h01), b);
            if (op >= `CAIO_OP_ADDW) begin
                cmd(op, rd, 5'h00, {2'b00, v[5:0]}, 3'h0);
                check(q[2:0], 3'b000);
                ew = alu16(op == `CAIO_OP_SUBW, {b, a}, v[5:0], sr);
                bus(1'b0, rfa(rd), 8'h00);
                a = q[7:0];
                bus(1'b0, rfa(rd + 5'h01), 8'h00);
                check({q[7:0], a}, ew[15:0]);
                ex = {ew[23:16], 8'h00};
            end else begin
                cmd(op, rd, rd + 5'h01, b, 3'h0);
                check(q[2:0], 3'b000);
                ex = alu8(op, a, b, sr);
                bus(1'b0, rfa(rd), 8'h00);
                check(q[7:0], ex[7:0]);
            end
            bus(1'b0, `CAIO_A_SREG, 8'h00);
            check(q[7:0], ex[15:8]);
        end
        a = rnd();
        b = rnd();
        bus(1'b1, dsa(8'h5f), a);
        cmd(`CAIO_OP_IN, 5'h03, 5'h00, 8'h3f, 3'h0);
        bus(1'b0, rfa(5'h03), 8'h00);
        check(q[7:0], a);
        bus(1'b1, rfa(5'h04), b);
        cmd(`CAIO_OP_OUT, 5'h04, 5'h00, 8'h20, 3'h0);
        bus(1'b0, dsa(8'h40), 8'h00);
        check(q[7:0], b);
        cmd(`CAIO_OP_IN, 5'h03, 5'h00, 8'h40, 3'h0);
        check(q[2], 1'b1);
        bus(1'b0, rfa(5'h03), 8'h00);
        check(q[7:0], a);
        cmd(`CAIO_OP_MWR, 5'h04, 5'h00, 8'hff, 3'h0);
        bus(1'b0, dsa(8'hff), 8'h00);
        check(q[7:0], b);
        bus(1'b1, dsa(8'h60), ~a);
        cmd(`CAIO_OP_MRD, 5'h05, 5'h00, 8'h60, 3'h0);
        bus(1'b0, rfa(5'h05), 8'h00);
        check(q[7:0], a ^ 8'hff);
        for (k = 0; k < 16; k = k + 1) begin
            v = rnd();
            bt = k[2:0];
            p = k[3] ? `CAIO_IO_BIT_MAX : 8'h00;
            bus(1'b1, dsa(p + `CAIO_IO_OFS), v);
            cmd(`CAIO_OP_SKBS, 5'h00, 5'h00, p, bt);
            check(q[1], v[bt]);
            cmd(`CAIO_OP_SKBC, 5'h00, 5'h00, p, bt);
            check(q[1], !v[bt]);
            cmd(`CAIO_OP_BSET, 5'h00, 5'h00, p, bt);
            bus(1'b0, dsa(p + `CAIO_IO_OFS), 8'h00);
            check(q[7:0], v | (8'h01 << bt));
            cmd(`CAIO_OP_BCLR, 5'h00, 5'h00, p, bt);
            bus(1'b0, dsa(p + `CAIO_IO_OFS), 8'h00);
            check(q[7:0], v & ~(8'h01 << bt));
        end
        bus(1'b1, dsa(8'h40), v);
        cmd(`CAIO_OP_BSET, 5'h00, 5'h00, 8'h20, ~bt);
        check(q[2], 1'b1);
        bus(1'b0, dsa(8'h40), 8'h00);
        check(q[7:0], v);
        cmd(5'h1f, 5'h00, 5'h00, 8'h00, 3'h0);
        check(q[2], 1'b1);
        bus(1'b1, 12'h01c, 8'h5a);
        bus(1'b0, 12'h01c, 8'h00);
        check(q, 32'h0);
        final_report;
    end
endmodule
